// *** oss_pkg.sv ***
/*
 Constants, field layout and types of the oscillator source select block.
 Assumes a 32-bit AXI4-Lite register bus and one 10 MHz system clock.
*/
`default_nettype none
package oss_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] CTRL_OFS    = 12'h000;
	localparam logic [11:0] TRIM_OFS    = 12'h004;
	localparam logic [11:0] STAT_OFS    = 12'h008;
	localparam int          CUR_LSB     = 12;
	localparam int          NXT_LSB     = 8;
	localparam int          LOCK_BIT    = 5;
	localparam int          KEEP_BIT    = 1;
	localparam int          GO_BIT      = 0;
	localparam int          TRIM_W      = 6;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
	localparam logic [5:0]  TRIM_RESET  = 6'h00;
	// ==========================================================
	// Source groups
	localparam logic [2:0] GRP_PLL    = 3'h7;
	localparam logic [2:0] GRP_DIRECT = 3'h3;
	localparam logic [2:0] GRP_SEC    = 3'h0;
	localparam logic [2:0] GRP_FRC    = 3'h1;
	localparam logic [2:0] GRP_SLOW   = 3'h2;
	// ==========================================================
	// Primary mode codes
	localparam logic [4:0] M_EXT_PLL4  = 5'h0d;
	localparam logic [4:0] M_EXT_PLL8  = 5'h0e;
	localparam logic [4:0] M_EXT_PLL16 = 5'h0f;
	localparam logic [4:0] M_XT_PLL4   = 5'h05;
	localparam logic [4:0] M_XT_PLL8   = 5'h06;
	localparam logic [4:0] M_XT_PLL16  = 5'h07;
	localparam logic [4:0] M_HS2_PLL4  = 5'h11;
	localparam logic [4:0] M_HS2_PLL8  = 5'h12;
	localparam logic [4:0] M_HS2_PLL16 = 5'h13;
	localparam logic [4:0] M_HS3_PLL4  = 5'h15;
	localparam logic [4:0] M_HS3_PLL8  = 5'h16;
	localparam logic [4:0] M_HS3_PLL16 = 5'h17;
	localparam logic [4:0] M_FRC_PLL4  = 5'h01;
	localparam logic [4:0] M_FRC_PLL8  = 5'h0a;
	localparam logic [4:0] M_FRC_PLL16 = 5'h03;
	localparam logic [4:0] M_EXT_IO    = 5'h0c;
	localparam logic [4:0] M_XT        = 5'h04;
	localparam logic [4:0] M_HS        = 5'h02;
	localparam logic [4:0] M_EXT       = 5'h0b;
	localparam logic [4:0] M_RC        = 5'h09;
	localparam logic [4:0] M_RC_IO     = 5'h08;
	localparam logic [4:0] M_XTL       = 5'h00;
	// ==========================================================
	// Multiplier, pre-divider and start-up count
	localparam logic [1:0] MULT_NONE  = 2'h0;
	localparam logic [1:0] MULT_X4    = 2'h1;
	localparam logic [1:0] MULT_X8    = 2'h2;
	localparam logic [1:0] MULT_X16   = 2'h3;
	localparam logic [1:0] PREDIV_1   = 2'h1;
	localparam logic [1:0] PREDIV_2   = 2'h2;
	localparam logic [1:0] PREDIV_3   = 2'h3;
	localparam logic [9:0] START_LAST = 10'h3ff;
	localparam logic [9:0] START_ZERO = 10'h000;
	// ==========================================================
	// Clock source
	typedef enum logic [4:0] {
		SRC_PRIMARY = 5'h01,
		SRC_PLL     = 5'h02,
		SRC_SEC     = 5'h04,
		SRC_FRC     = 5'h08,
		SRC_SLOW    = 5'h10
	} oss_src_type;
endpackage
`default_nettype wire

// *** oss_top.sv ***
/*
 Oscillator source select: fuse-based start-up choice, start-up counter,
 secondary keep-on, PLL multiplier and lock, fast RC trim, pin functions.
 Assumes fuses stable, osc_tick_i one pulse per oscillator period, and an
 AXI4-Lite master that follows the usual valid/ready rules.
*/
// Contract
// - At POR/BOR pick clock from 3-bit group and 5-bit mode fuses.
// - Groups 111 PLL, 011 direct, 000 secondary, 001 fast RC, 010 slow RC.
// - Group 111 with modes 00101/00110/00111 applies x4/x8/x16.
// - Start-up counter is 10 bits and counts 1024 oscillator periods.
// - Start-up delay on power-on, brown-out and wake from sleep.
// - Start-up delay only for crystal modes, not clock input, RC or PLL-only.
// - Secondary oscillator runs, also in sleep, while keep-on is 1.
// - Secondary is device clock only with group 000 and keep-on set.
// - Returning from secondary to primary still costs the start-up delay.
// - PLL gain selectable as four, eight or sixteen.
// - PLL lock level mirrored in a read-only control register bit.
// - Group 001 in bits 14:12 runs the device from fast RC.
// - Six-bit trim steps fast RC frequency by 0.4 percent.
// - Trim is two's complement, zero centre, 011111 top, 100000 bottom.
// - Crystal out pin function depends only on the mode fuses.
// - Crystal in pin is never general-purpose I/O.
// - POR/BOR loads current and next group from the group fuses.
`timescale 1ns/100ps
`default_nettype none
module oss_top (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic [2:0]  source_group_fuses_i,
	input  wire logic [4:0]  primary_mode_fuses_i,
	input  wire logic        osc_tick_i,
	input  wire logic        sleep_i,
	input  wire logic        pll_lock_i,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             sys_clk_en_o,
	output logic [4:0]       clock_source_o,
	output logic [1:0]       pll_mult_o,
	output logic [1:0]       pll_prediv_o,
	output logic             secondary_osc_en_o,
	output logic             primary_osc_en_o,
	output logic [5:0]       fast_rc_trim_o,
	output logic             crystal_out_gpio_o,
	output logic             crystal_out_clk_o,
	output logic             crystal_in_gpio_o
);
	// ==========================================================
	// Bus handshake
	logic        aw_ok_ff, nxt_aw_ok;
	logic [11:0] awaddr_ff, nxt_awaddr;
	logic        w_ok_ff, nxt_w_ok;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0]  wstrb_ff, nxt_wstrb;
	logic        bvalid_ff, nxt_bvalid;
	logic [1:0]  bresp_ff, nxt_bresp;
	logic        awready_ff, nxt_awready;
	logic        wready_ff, nxt_wready;
	logic        arready_ff, nxt_arready;
	logic        rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0]  rresp_ff, nxt_rresp;
	logic        wr_fire;
	logic [31:0] wr_mask;
	logic [31:0] rd_word;
	logic        rd_hit;
	// ==========================================================
	// Clock control state
	logic [2:0]  cur_grp_ff, nxt_cur_grp;
	logic [2:0]  next_grp_ff, nxt_next_grp;
	logic        keep_on_ff, nxt_keep_on;
	logic [5:0]  trim_ff, nxt_trim;
	logic        lock_ff, nxt_lock;
	logic [9:0]  cnt_ff, nxt_cnt;
	logic        done_ff, nxt_done;
	logic        sleep_q_ff, nxt_sleep_q;
	logic        clk_en_ff, nxt_clk_en;
	oss_pkg::oss_src_type src_ff, nxt_src;
	logic [1:0]  mult_ff, nxt_mult;
	logic [1:0]  prediv_ff, nxt_prediv;
	logic        sec_en_ff, nxt_sec_en;
	logic        pri_en_ff, nxt_pri_en;
	logic        out_gpio_ff, nxt_out_gpio;
	logic        out_clk_ff, nxt_out_clk;
	logic        needs_start;
	logic        restart;
	logic        go;

	assign wr_fire = aw_ok_ff && w_ok_ff && !bvalid_ff;
	assign wr_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

	// ==========================================================
	// Read mux
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = oss_pkg::ZERO_WORD;
		unique case (s_axi_araddr[11:0])
			oss_pkg::CTRL_OFS: begin
				rd_word[oss_pkg::CUR_LSB +: 3] = cur_grp_ff;
				rd_word[oss_pkg::NXT_LSB +: 3] = next_grp_ff;
				rd_word[oss_pkg::LOCK_BIT]     = lock_ff;
				rd_word[oss_pkg::KEEP_BIT]     = keep_on_ff;
			end
			oss_pkg::TRIM_OFS: rd_word[oss_pkg::TRIM_W-1:0] = trim_ff;
			oss_pkg::STAT_OFS: begin
				rd_word[0]   = done_ff;
				rd_word[1]   = clk_en_ff;
				rd_word[3:2] = mult_ff;
				rd_word[8:4] = src_ff;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Bus next state
	always_comb begin
		nxt_aw_ok  = aw_ok_ff;
		nxt_awaddr = awaddr_ff;
		nxt_w_ok   = w_ok_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_awvalid && awready_ff) begin
			nxt_aw_ok  = 1'b1;
			nxt_awaddr = s_axi_awaddr[11:0];
		end
		if (s_axi_wvalid && wready_ff) begin
			nxt_w_ok  = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			nxt_aw_ok  = 1'b0;
			nxt_w_ok   = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = oss_pkg::RESP_OKAY;
			if (awaddr_ff != oss_pkg::CTRL_OFS && awaddr_ff != oss_pkg::TRIM_OFS) begin
				nxt_bresp = oss_pkg::RESP_SLVERR;
			end
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && arready_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_word;
			nxt_rresp  = rd_hit ? oss_pkg::RESP_OKAY : oss_pkg::RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		nxt_awready = !nxt_aw_ok && !nxt_bvalid;
		nxt_wready  = !nxt_w_ok && !nxt_bvalid;
		nxt_arready = !nxt_rvalid;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			aw_ok_ff   <= 1'b0;
			awaddr_ff  <= oss_pkg::CTRL_OFS;
			w_ok_ff    <= 1'b0;
			wdata_ff   <= oss_pkg::ZERO_WORD;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= oss_pkg::RESP_OKAY;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= oss_pkg::ZERO_WORD;
			rresp_ff   <= oss_pkg::RESP_OKAY;
		end else begin
			aw_ok_ff   <= nxt_aw_ok;
			awaddr_ff  <= nxt_awaddr;
			w_ok_ff    <= nxt_w_ok;
			wdata_ff   <= nxt_wdata;
			wstrb_ff   <= nxt_wstrb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			awready_ff <= nxt_awready;
			wready_ff  <= nxt_wready;
			arready_ff <= nxt_arready;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
		end
	end

	// ==========================================================
	// Clock control next state
	always_comb begin
		nxt_next_grp = next_grp_ff;
		nxt_keep_on  = keep_on_ff;
		nxt_trim     = trim_ff;
		go           = 1'b0;
		if (wr_fire && awaddr_ff == oss_pkg::CTRL_OFS) begin
			if (wstrb_ff[1]) begin
				nxt_next_grp = wdata_ff[oss_pkg::NXT_LSB +: 3];
			end
			if (wstrb_ff[0]) begin
				nxt_keep_on = wdata_ff[oss_pkg::KEEP_BIT];
				go          = wdata_ff[oss_pkg::GO_BIT];
			end
		end
		if (wr_fire && awaddr_ff == oss_pkg::TRIM_OFS) begin
			// Two's complement step code, passed on untouched
			nxt_trim = (wdata_ff[oss_pkg::TRIM_W-1:0] & wr_mask[oss_pkg::TRIM_W-1:0])
				| (trim_ff & ~wr_mask[oss_pkg::TRIM_W-1:0]);
		end
		// Minimal switch: go copies the requested group into the current one
		nxt_cur_grp = go ? next_grp_ff : cur_grp_ff;
		nxt_lock    = pll_lock_i;
		nxt_sleep_q = sleep_i;

		// Source decode from current group and mode fuses
		nxt_src      = oss_pkg::SRC_SLOW;
		nxt_mult     = oss_pkg::MULT_NONE;
		nxt_prediv   = oss_pkg::PREDIV_1;
		needs_start  = 1'b0;
		unique case (nxt_cur_grp)
			oss_pkg::GRP_PLL: begin
				nxt_src = oss_pkg::SRC_PLL;
				unique case (primary_mode_fuses_i)
					oss_pkg::M_EXT_PLL4, oss_pkg::M_XT_PLL4, oss_pkg::M_HS2_PLL4,
					oss_pkg::M_HS3_PLL4, oss_pkg::M_FRC_PLL4: nxt_mult = oss_pkg::MULT_X4;
					oss_pkg::M_EXT_PLL8, oss_pkg::M_XT_PLL8, oss_pkg::M_HS2_PLL8,
					oss_pkg::M_HS3_PLL8, oss_pkg::M_FRC_PLL8: nxt_mult = oss_pkg::MULT_X8;
					oss_pkg::M_EXT_PLL16, oss_pkg::M_XT_PLL16, oss_pkg::M_HS2_PLL16,
					oss_pkg::M_HS3_PLL16, oss_pkg::M_FRC_PLL16: nxt_mult = oss_pkg::MULT_X16;
					default: nxt_mult = oss_pkg::MULT_NONE;
				endcase
				unique case (primary_mode_fuses_i)
					oss_pkg::M_HS2_PLL4, oss_pkg::M_HS2_PLL8,
					oss_pkg::M_HS2_PLL16: nxt_prediv = oss_pkg::PREDIV_2;
					oss_pkg::M_HS3_PLL4, oss_pkg::M_HS3_PLL8,
					oss_pkg::M_HS3_PLL16: nxt_prediv = oss_pkg::PREDIV_3;
					default: nxt_prediv = oss_pkg::PREDIV_1;
				endcase
				// Crystal-fed PLL waits; clock-input and RC-fed PLL do not
				needs_start = primary_mode_fuses_i[4] ||
					primary_mode_fuses_i[4:2] == oss_pkg::M_XT_PLL4[4:2];
			end
			oss_pkg::GRP_DIRECT: begin
				nxt_src     = oss_pkg::SRC_PRIMARY;
				needs_start = primary_mode_fuses_i == oss_pkg::M_XT ||
					primary_mode_fuses_i == oss_pkg::M_HS ||
					primary_mode_fuses_i == oss_pkg::M_XTL;
			end
			oss_pkg::GRP_SEC: begin
				// Without keep-on the secondary is stopped; fall back to slow RC
				nxt_src     = nxt_keep_on ? oss_pkg::SRC_SEC : oss_pkg::SRC_SLOW;
				needs_start = nxt_keep_on;
			end
			oss_pkg::GRP_FRC: nxt_src = oss_pkg::SRC_FRC;
			default: nxt_src = oss_pkg::SRC_SLOW;
		endcase

		// Start-up counter, restarted on wake and on each switch
		restart  = (sleep_q_ff && !sleep_i) || go;
		nxt_cnt  = cnt_ff;
		nxt_done = done_ff;
		if (restart) begin
			nxt_cnt  = oss_pkg::START_ZERO;
			nxt_done = 1'b0;
		end else if (!done_ff && osc_tick_i && !sleep_i) begin
			if (cnt_ff == oss_pkg::START_LAST) begin
				nxt_cnt  = oss_pkg::START_ZERO;
				nxt_done = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 10'h001;
			end
		end
		// Gate held low through sleep and the start-up count
		nxt_clk_en = !sleep_i && (nxt_done || !needs_start);
		nxt_sec_en = nxt_keep_on;
		nxt_pri_en = !sleep_i && (nxt_src == oss_pkg::SRC_PRIMARY || nxt_src == oss_pkg::SRC_PLL);

		// Pin use follows the mode fuses alone
		nxt_out_gpio = 1'b0;
		nxt_out_clk  = 1'b0;
		unique case (primary_mode_fuses_i)
			oss_pkg::M_EXT_IO, oss_pkg::M_EXT_PLL4, oss_pkg::M_EXT_PLL8,
			oss_pkg::M_EXT_PLL16, oss_pkg::M_FRC_PLL4, oss_pkg::M_FRC_PLL8,
			oss_pkg::M_FRC_PLL16, oss_pkg::M_RC_IO: nxt_out_gpio = 1'b1;
			oss_pkg::M_EXT, oss_pkg::M_RC: nxt_out_clk = 1'b1;
			default: nxt_out_gpio = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			// Fuses are read on the synchronous reset itself
			cur_grp_ff  <= source_group_fuses_i;
			next_grp_ff <= source_group_fuses_i;
			keep_on_ff  <= 1'b0;
			trim_ff     <= oss_pkg::TRIM_RESET;
			lock_ff     <= 1'b0;
			cnt_ff      <= oss_pkg::START_ZERO;
			done_ff     <= 1'b0;
			sleep_q_ff  <= 1'b0;
			clk_en_ff   <= 1'b0;
			src_ff      <= oss_pkg::SRC_SLOW;
			mult_ff     <= oss_pkg::MULT_NONE;
			prediv_ff   <= oss_pkg::PREDIV_1;
			sec_en_ff   <= 1'b0;
			pri_en_ff   <= 1'b0;
			out_gpio_ff <= 1'b0;
			out_clk_ff  <= 1'b0;
		end else begin
			cur_grp_ff  <= nxt_cur_grp;
			next_grp_ff <= nxt_next_grp;
			keep_on_ff  <= nxt_keep_on;
			trim_ff     <= nxt_trim;
			lock_ff     <= nxt_lock;
			cnt_ff      <= nxt_cnt;
			done_ff     <= nxt_done;
			sleep_q_ff  <= nxt_sleep_q;
			clk_en_ff   <= nxt_clk_en;
			src_ff      <= nxt_src;
			mult_ff     <= nxt_mult;
			prediv_ff   <= nxt_prediv;
			sec_en_ff   <= nxt_sec_en;
			pri_en_ff   <= nxt_pri_en;
			out_gpio_ff <= nxt_out_gpio;
			out_clk_ff  <= nxt_out_clk;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready      = awready_ff;
	assign s_axi_wready       = wready_ff;
	assign s_axi_bvalid       = bvalid_ff;
	assign s_axi_bresp        = bresp_ff;
	assign s_axi_arready      = arready_ff;
	assign s_axi_rvalid       = rvalid_ff;
	assign s_axi_rdata        = rdata_ff;
	assign s_axi_rresp        = rresp_ff;
	assign sys_clk_en_o       = clk_en_ff;
	assign clock_source_o     = src_ff;
	assign pll_mult_o         = mult_ff;
	assign pll_prediv_o       = prediv_ff;
	assign secondary_osc_en_o = sec_en_ff;
	assign primary_osc_en_o   = pri_en_ff;
	assign fast_rc_trim_o     = trim_ff;
	assign crystal_out_gpio_o = out_gpio_ff;
	assign crystal_out_clk_o  = out_clk_ff;
	// Constant by design: never a register so no write can free it
	assign crystal_in_gpio_o  = 1'b0;
endmodule
`default_nettype wire

// *** oss_top_monitor.sv ***
/*
 Checker for the oscillator source select block, bound to oss_top.
 Assumes one clock domain and the top ports as declared.
*/
`timescale 1ns/100ps
`default_nettype none
module oss_check (
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	input wire logic [4:0]  primary_mode_fuses_i,
	input wire logic        osc_tick_i,
	input wire logic        sleep_i,
	input wire logic        pll_lock_i,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        sys_clk_en_o,
	input wire logic [4:0]  clock_source_o,
	input wire logic [1:0]  pll_mult_o,
	input wire logic        secondary_osc_en_o,
	input wire logic        crystal_out_gpio_o,
	input wire logic        crystal_out_clk_o,
	input wire logic        crystal_in_gpio_o
);
	// ==========================================================
	// Tick count since reset or sleep
	logic [10:0] cnt_ff;
	logic [10:0] nxt_cnt;
	logic        woke_ff;
	logic        nxt_woke;
	logic        xtal;
	logic        ar_ctrl;
	assign xtal = clock_source_o == oss_pkg::SRC_PRIMARY
		&& primary_mode_fuses_i inside {oss_pkg::M_XT, oss_pkg::M_HS, oss_pkg::M_XTL};
	assign ar_ctrl = s_axi_arvalid && s_axi_arready && s_axi_araddr[11:0] == oss_pkg::CTRL_OFS;
	// Go writes are not seen here, so this count can only run ahead of the design's
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_woke = (woke_ff || sleep_i) && !reset_i;
		if (reset_i || sleep_i)
			nxt_cnt = 11'h000;
		else if (osc_tick_i && cnt_ff != 11'h400)
			nxt_cnt = cnt_ff + 11'h001;
	end
	always_ff @(posedge ref_clk_i) begin
		cnt_ff <= nxt_cnt;
		woke_ff <= nxt_woke;
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);
	a_xin_not_io: assert property (!crystal_in_gpio_o)
		else $error("crystal in pin set as io");
	a_xout_one_use: assert property (!(crystal_out_gpio_o && crystal_out_clk_o))
		else $error("crystal out pin both io and clock");
	a_src_one_hot: assert property ($onehot(clock_source_o))
		else $error("clock source not one-hot");
	a_sec_needs_keep: assert property (clock_source_o == oss_pkg::SRC_SEC
		|-> secondary_osc_en_o) else $error("secondary source without keep-on");
	a_pll_has_gain: assert property (clock_source_o == oss_pkg::SRC_PLL
		|-> pll_mult_o != oss_pkg::MULT_NONE) else $error("pll source without gain");
	a_sleep_gates_en: assert property (sleep_i |=> !sys_clk_en_o)
		else $error("clock passed in sleep");
	a_en_held_off: assert property (xtal && cnt_ff < 11'h400 |-> !sys_clk_en_o)
		else $error("clock passed before start-up count");
	a_en_at_count: assert property (xtal && !woke_ff && cnt_ff == 11'h3ff
		&& osc_tick_i && !sleep_i |=> sys_clk_en_o) else $error("clock not passed at count");
	a_lock_seen: assert property (ar_ctrl && pll_lock_i == $past(pll_lock_i)
		|=> s_axi_rdata[oss_pkg::LOCK_BIT] == $past(pll_lock_i)) else $error("lock bit wrong");
	a_frc_group: assert property (ar_ctrl && clock_source_o == oss_pkg::SRC_FRC
		|=> s_axi_rdata[14:12] == oss_pkg::GRP_FRC) else $error("fast rc group wrong");
	c_en_rise: cover property ($rose(sys_clk_en_o));
	c_sec_src: cover property (clock_source_o == oss_pkg::SRC_SEC);
	c_lock_read: cover property (ar_ctrl && pll_lock_i);
endmodule
bind oss_top oss_check i_oss_check (.ref_clk_i, .reset_i, .primary_mode_fuses_i, .osc_tick_i,
	.sleep_i, .pll_lock_i, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.sys_clk_en_o, .clock_source_o, .pll_mult_o, .secondary_osc_en_o, .crystal_out_gpio_o,
	.crystal_out_clk_o, .crystal_in_gpio_o);
`default_nettype wire

// *** oss_osc_model.sv ***
/*
 Far side: oscillator ticks and PLL lock.
 Assumes run_i high while the block enables an oscillator.
*/
`timescale 1ns/100ps
`default_nettype none
module oss_osc_model #(
	parameter int DIV      = 2,
	parameter int LOCK_DLY = 8
) (
	input  wire logic ref_clk_i,
	input  wire logic run_i,
	input  wire logic pll_i,
	input  wire logic drop_lock_i,
	output logic      tick_o,
	output logic      lock_o
);
	int   div_ff = 0;
	int   lock_ff = 0;
	logic tick_ff = 1'b0;
	// Stands still while disabled, so no tick can leak into a start-up count
	always_ff @(posedge ref_clk_i) begin
		div_ff <= run_i ? (div_ff + 1) % DIV : 0;
		tick_ff <= run_i && div_ff == DIV - 1;
		lock_ff <= (run_i && pll_i) ? ((lock_ff < LOCK_DLY) ? lock_ff + 1 : lock_ff) : 0;
	end
	assign tick_o = tick_ff;
	assign lock_o = lock_ff == LOCK_DLY && !drop_lock_i;
endmodule
`default_nettype wire

// *** tb.sv ***
/*
 Self-checking bench for oss_top: fuse decode, start-up gating, registers.
 Assumes oss_osc_model as far side and a 10 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        ref_clk = 1'b0, rst = 1'b1, slp = 1'b0, drop = 1'b0;
	logic [2:0]  grp = 3'h3;
	logic [4:0]  mode = 5'h04;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, tick, lock, en, sec, pri;
	logic        xo_io, xo_ck, xi_io;
	logic [1:0]  bresp, rresp, mult, pdiv, resp;
	logic [4:0]  src;
	logic [5:0]  trim, tv;
	logic [11:0] e;
	logic [7:0]  tab [25] = '{8'hed, 8'hee, 8'hef, 8'he1, 8'hea, 8'he3, 8'he5, 8'he6, 8'he7,
		8'hf1, 8'hf2, 8'hf3, 8'hf5, 8'hf6, 8'hf7, 8'h6c, 8'h64, 8'h62, 8'h6b, 8'h69, 8'h68,
		8'h60, 8'h04, 8'h24, 8'h44};
	int          bad_count = 0, n_compared = 0, seed = 32'h90d3, i;
	always #50 ref_clk = ~ref_clk;
	oss_top i_oss_top (.ref_clk_i(ref_clk), .reset_i(rst), .source_group_fuses_i(grp),
		.primary_mode_fuses_i(mode), .osc_tick_i(tick), .sleep_i(slp), .pll_lock_i(lock),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sys_clk_en_o(en), .clock_source_o(src), .pll_mult_o(mult), .pll_prediv_o(pdiv),
		.secondary_osc_en_o(sec), .primary_osc_en_o(pri), .fast_rc_trim_o(trim),
		.crystal_out_gpio_o(xo_io), .crystal_out_clk_o(xo_ck), .crystal_in_gpio_o(xi_io));
	oss_osc_model i_oss_osc_model (.ref_clk_i(ref_clk), .run_i(pri | sec),
		.pll_i(src == oss_pkg::SRC_PLL), .drop_lock_i(drop), .tick_o(tick), .lock_o(lock));
	// ==========================================================
	// Reference model: {start-up, io, clk out, prediv, mult, source}
	function automatic logic [11:0] model(input logic [2:0] g, input logic [4:0] m);
		logic [4:0] s;
		logic [1:0] mu, pd;
		logic       io, co, nd;
		io = m inside {5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h01, 5'h0a, 5'h03, 5'h08};
		co = m inside {5'h0b, 5'h09};
		mu = 2'h0;
		pd = 2'h1;
		nd = 1'b0;
		case (g)
			3'h7: begin
				s = 5'h02;
				mu = m[1:0];
				pd = m[4] ? (m[2] ? 2'h3 : 2'h2) : 2'h1;
				nd = m[4] || m[4:2] == 3'h1;
			end
			3'h3: begin
				s = 5'h01;
				nd = m inside {5'h04, 5'h02, 5'h00};
			end
			3'h1: s = 5'h08;
			default: s = 5'h10;
		endcase
		return {nd, io, co, pd, mu, s};
	endfunction
	// ==========================================================
	// Tasks
	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s exp %h seen %h", w, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic give_up(input string w);
		bad_count++;
		$display("[FAIL] %s exp answer seen timeout", w);
		test_done();
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic ticks(input int n);
		int k;
		for (k = 0; n > 0 && k < 9000; k++) begin
			@(posedge ref_clk);
			if (tick === 1'b1)
				n--;
		end
		if (n > 0)
			give_up("tick");
	endtask
	task automatic wait_en();
		int k;
		for (k = 0; en !== 1'b1 && k < 9000; k++)
			@(posedge ref_clk);
		if (k == 9000)
			give_up("clk_en");
	endtask
	task automatic boot(input logic [2:0] g, input logic [4:0] m);
		@(posedge ref_clk);
		rst <= 1'b1;
		grp <= g;
		mode <= m;
		step(20);
		rst <= 1'b0;
		step(2);
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] v);
		int k;
		@(posedge ref_clk);
		awaddr <= {20'h0, a};
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50 && bvalid !== 1'b1; k++) begin
			@(posedge ref_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		if (k == 50)
			give_up("bvalid");
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a);
		int k;
		@(posedge ref_clk);
		araddr <= {20'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50 && rvalid !== 1'b1; k++) begin
			@(posedge ref_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		if (k == 50)
			give_up("rvalid");
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		for (i = 0; i < 25; i++) begin
			boot(tab[i][7:5], tab[i][4:0]);
			e = model(tab[i][7:5], tab[i][4:0]);
			chk("source", src, e[4:0]);
			chk("mult", mult, e[6:5]);
			if (grp == 3'h7)
				chk("prediv", pdiv, e[8:7]);
			chk("xo_io", xo_io, e[10]);
			chk("xo_clk", xo_ck, e[9]);
			chk("xi_io", xi_io, 1'b0);
			chk("pri_en", pri, |e[1:0]);
			if (e[11]) begin
				chk("en_early", en, 1'b0);
				ticks(1023);
				step(1);
				chk("en_1023", en, 1'b0);
				ticks(1);
				step(1);
			end
			chk("en", en, 1'b1);
			axr(12'h000);
			chk("ctrl_grp", d & 32'h7700, {17'h0, grp, 1'b0, grp, 8'h0});
			if (grp == 3'h7) begin
				step(20);
				axr(12'h000);
				chk("lock", d[5], 1'b1);
				drop <= 1'b1;
				step(3);
				axr(12'h000);
				chk("unlock", d[5], 1'b0);
				drop <= 1'b0;
			end
		end
		$display("fuse table test ended");
		for (i = 0; i < 6; i++) begin
			// Source here is not the x16 fast RC path, so any trim is legal
			tv = i == 0 ? 6'h1f : i == 1 ? 6'h20 : 6'($random(seed));
			axw(12'h004, {26'h0, tv});
			chk("trim_resp", resp, 2'h0);
			step(2);
			chk("trim_pin", trim, tv);
			axr(12'h004);
			chk("trim_rd", d, {26'h0, tv});
		end
		axr(12'h00c);
		chk("unmapped_resp", resp, 2'h2);
		chk("unmapped_data", d, 32'h0);
		axw(12'h008, 32'hffff_ffff);
		chk("stat_wr_resp", resp, 2'h2);
		$display("register test ended");
		boot(3'h3, 5'h04);
		wait_en();
		axw(12'h000, 32'h0000_0302);
		step(2);
		chk("keep_on", sec, 1'b1);
		slp <= 1'b1;
		step(5);
		chk("keep_sleep", sec, 1'b1);
		chk("en_sleep", en, 1'b0);
		chk("pri_sleep", pri, 1'b0);
		slp <= 1'b0;
		ticks(1000);
		chk("en_wake", en, 1'b0);
		wait_en();
		// Go copies the group already held, so the next group lands first
		axw(12'h000, 32'h0000_0002);
		axw(12'h000, 32'h0000_0003);
		step(2);
		chk("src_sec", src, 5'h04);
		wait_en();
		axw(12'h000, 32'h0000_0302);
		axw(12'h000, 32'h0000_0303);
		step(2);
		chk("en_back", en, 1'b0);
		ticks(1000);
		chk("en_back_wait", en, 1'b0);
		wait_en();
		chk("src_pri", src, 5'h01);
		axr(12'h008);
		chk("stat", d, 32'h0000_0013);
		$display("keep-on test ended");
		test_done();
	end
endmodule
`default_nettype wire
